//--- design/uabg_baud_gen.sv
// module: baud rate generator with separate tx/rx divide counters and receive-line noise filter
// assumes: plain register port, synchronous serial_rx_line, framing/shifting done by the surrounding unit
//
// Contract
// RL1: receive line sampled on base clock; filtered level changes only when two samples agree.
// RL2: filtered receive level lags the pin by two base clocks.
// RL3: clock selector feeds separate 5-bit divide counters for transmit and receive; the rx counter here is 6 bits, counting to 2k.
// RL4: select bits 7:6 choose base clock; no base clock while power bit is 0.
// RL5: tx counter held at zero unless power and tx enable are both 1.
// RL6: tx counter cleared when first byte is written after enabling.
// RL7: rx counter held at zero unless power and rx enable are both 1.
// RL8: rx counter runs from start detection and stops after one frame.
// RL9: bits 4:0 give divide value k, legal from 8 to 31.
// RL10: bit rate is base clock divided by two times k.
// RL11: receive latch instants timed by rx counter from start detection.
// RL12: latch points keep two base clocks of margin; tolerance assumes 11-bit frame.
// RL13: remote transmitter keeps its rate within the receiver tolerance.
// RL14: software picks a transmit rate within the far receiver's tolerance.
// RL15: on filtered falling edge count k, resample, accept start only if still low.
// RL16: frame is start, 7 or 8 bits lsb first, optional parity, 1 or 2 stops.
// RL17: receiver checks one stop bit and ignores a second one.
// RL18: after start confirmation every later bit is latched each 2k base clocks.
`timescale 1ns/1ps
`default_nettype none
module uabg_baud_gen #(
  parameter int unsigned PRE_W = uabg_pkg::PRE_W
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_reset_n,
  input  wire logic [uabg_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [uabg_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [uabg_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                        i_serial_rx_line,
  output logic                             o_base_clk_en,
  output logic                             o_tx_bit_tick,
  output logic                             o_tx_load,
  output logic      [uabg_pkg::DATA_W-1:0] o_tx_data,
  output logic                             o_rx_filtered,
  output logic                             o_rx_start,
  output logic                             o_rx_latch,
  output logic                             o_rx_bit,
  output logic                             o_rx_frame_end
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the slowest base clock is core/8, so the prescaler needs at least three bits
  if (PRE_W < 3 || PRE_W > 8) begin : g_bad_pre
    $error("uabg_baud_gen: PRE_W must lie in 3..8");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] div_q, div_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] txd_q, txd_d;
  logic       tx_load_q, tx_load_d;

  logic power, txe, rxe;
  logic [1:0] sel;
  logic [4:0] k_eff;

  assign power = mode_q[uabg_pkg::MODE_POWER];
  assign txe   = mode_q[uabg_pkg::MODE_TXE];
  assign rxe   = mode_q[uabg_pkg::MODE_RXE];
  assign sel   = {div_q[uabg_pkg::DIV_SEL_HI], div_q[uabg_pkg::DIV_SEL_LO]};

  // values below 8 would break the start-bit margin, so they run as 8
  assign k_eff = (div_q[uabg_pkg::DIV_K_MSB:uabg_pkg::DIV_K_LSB] < uabg_pkg::K_MIN) ?
                 uabg_pkg::K_MIN : div_q[uabg_pkg::DIV_K_MSB:uabg_pkg::DIV_K_LSB];   // [RL9]

  uabg_pkg::uabg_rx_state_t rx_st_q, rx_st_d;
  logic [5:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_idx_q, rx_idx_d;
  logic       tx_run;
  logic       rx_filt;
  logic [7:0] status;

  assign status = {rx_st_q == uabg_pkg::UABG_RX_FRAME, rx_st_q == uabg_pkg::UABG_RX_CONFIRM,
                   tx_run, rx_filt, rx_idx_q};

  always_comb begin
    div_d     = div_q;
    mode_d    = mode_q;
    txd_d     = txd_q;
    tx_load_d = 1'b0;
    rdata_d   = 8'h00;
    if (i_wr) begin
      if (i_addr == uabg_pkg::OFS_DIV_CTRL) begin
        div_d = i_wdata;
      end else if (i_addr == uabg_pkg::OFS_MODE_CTRL) begin
        mode_d = i_wdata;
      end else if (i_addr == uabg_pkg::OFS_TX_SHIFT) begin
        txd_d     = i_wdata;
        tx_load_d = 1'b1;
      end
    end
    if (i_rd) begin
      if (i_addr == uabg_pkg::OFS_DIV_CTRL) begin
        rdata_d = div_q;
      end else if (i_addr == uabg_pkg::OFS_MODE_CTRL) begin
        rdata_d = mode_q;
      end else if (i_addr == uabg_pkg::OFS_STATUS) begin
        rdata_d = status;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_q     <= uabg_pkg::DIV_RST;
      mode_q    <= uabg_pkg::MODE_RST;
      txd_q     <= 8'h00;
      tx_load_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      div_q     <= div_d;
      mode_q    <= mode_d;
      txd_q     <= txd_d;
      tx_load_q <= tx_load_d;
      rdata_q   <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // base clock selector
  // ----------------------------------------------------------------
  // base clock is a one-cycle enable of core/1, /2, /4 or /8
  logic [PRE_W-1:0] pre_q, pre_d;
  logic             base_q, base_d;
  logic [PRE_W-1:0] pre_mask;

  assign pre_mask = PRE_W'((1 << sel) - 1);

  always_comb begin
    pre_d  = '0;
    base_d = 1'b0;
    if (power) begin
      pre_d  = pre_q + PRE_W'(1);
      base_d = ((pre_q & pre_mask) == pre_mask);                 // [RL3] [RL4]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_q  <= '0;
      base_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      base_q <= base_d;
    end
  end

  // ----------------------------------------------------------------
  // transmit divide counter
  // ----------------------------------------------------------------
  logic [4:0] tx_cnt_q, tx_cnt_d;
  logic       tx_half_q, tx_half_d;
  logic       tx_first_q, tx_first_d;
  logic       tx_tick_q, tx_tick_d;

  assign tx_run = power & txe;

  always_comb begin
    tx_cnt_d   = tx_cnt_q;
    tx_half_d  = tx_half_q;
    tx_first_d = tx_first_q;
    tx_tick_d  = 1'b0;
    if (!tx_run) begin
      tx_cnt_d   = 5'h00;                                      // [RL5]
      tx_half_d  = 1'b0;
      tx_first_d = 1'b1;
    end else if (tx_load_q && tx_first_q) begin
      tx_cnt_d   = 5'h00;                                      // [RL6]
      tx_half_d  = 1'b0;
      tx_first_d = 1'b0;
    end else if (base_q) begin
      if (tx_cnt_q == k_eff - 5'h01) begin
        tx_cnt_d  = 5'h00;
        tx_half_d = ~tx_half_q;
        tx_tick_d = tx_half_q;                                 // [RL10]
      end else begin
        tx_cnt_d = tx_cnt_q + 5'h01;                           // [RL3]
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_cnt_q   <= 5'h00;
      tx_half_q  <= 1'b0;
      tx_first_q <= 1'b1;
      tx_tick_q  <= 1'b0;
    end else begin
      tx_cnt_q   <= tx_cnt_d;
      tx_half_q  <= tx_half_d;
      tx_first_q <= tx_first_d;
      tx_tick_q  <= tx_tick_d;
    end
  end

  // ----------------------------------------------------------------
  // receive noise filter
  // ----------------------------------------------------------------
  uabg_filt_if filt_bus ();

  assign filt_bus.sample_en = base_q;
  assign filt_bus.raw_line  = i_serial_rx_line;
  assign rx_filt            = filt_bus.filt_line;

  uabg_rx_filter uabg_rx_filter_inst (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .f          (filt_bus)
  );

  // ----------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------
  logic       rx_run;
  logic       prev_q, prev_d;
  logic       start_q, start_d;
  logic       latch_q, latch_d;
  logic       bit_q, bit_d;
  logic       end_q, end_d;
  logic [3:0] rx_total;
  logic [5:0] two_k;

  assign rx_run   = power & rxe;
  // second stop bit is never counted
  assign rx_total = uabg_pkg::RX_BITS_BASE + {3'h0, mode_q[uabg_pkg::MODE_CHAR8]}
                  + {3'h0, mode_q[uabg_pkg::MODE_PAR_EN]};     // [RL16] [RL17]
  assign two_k    = {k_eff, 1'b0};

  always_comb begin
    rx_st_d  = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_idx_d = rx_idx_q;
    prev_d   = prev_q;
    start_d  = 1'b0;
    latch_d  = 1'b0;
    bit_d    = bit_q;
    end_d    = 1'b0;
    if (!rx_run) begin
      rx_st_d  = uabg_pkg::UABG_RX_IDLE;                      // [RL7]
      rx_cnt_d = 6'h00;
      rx_idx_d = 4'h0;
      prev_d   = 1'b1;
    end else if (base_q) begin
      prev_d = rx_filt;
      case (rx_st_q)
        uabg_pkg::UABG_RX_IDLE: begin
          if (prev_q && !rx_filt) begin
            rx_st_d  = uabg_pkg::UABG_RX_CONFIRM;              // [RL15]
            rx_cnt_d = 6'h01;
          end
        end
        uabg_pkg::UABG_RX_CONFIRM: begin
          if (rx_cnt_q == {1'b0, k_eff}) begin
            rx_cnt_d = 6'h01;
            rx_idx_d = 4'h0;
            if (!rx_filt) begin
              rx_st_d = uabg_pkg::UABG_RX_FRAME;               // [RL15] [RL8]
              start_d = 1'b1;
            end else begin
              rx_st_d = uabg_pkg::UABG_RX_IDLE;
            end
          end else begin
            rx_cnt_d = rx_cnt_q + 6'h01;
          end
        end
        uabg_pkg::UABG_RX_FRAME: begin
          if (rx_cnt_q == two_k) begin
            rx_cnt_d = 6'h01;
            latch_d  = 1'b1;                                   // [RL11] [RL18] [RL12]
            bit_d    = rx_filt;
            rx_idx_d = rx_idx_q + 4'h1;
            if (rx_idx_q == rx_total - 4'h1) begin
              rx_st_d  = uabg_pkg::UABG_RX_IDLE;               // [RL8]
              rx_cnt_d = 6'h00;
              end_d    = 1'b1;
            end
          end else begin
            rx_cnt_d = rx_cnt_q + 6'h01;
          end
        end
        default: begin
          rx_st_d  = uabg_pkg::UABG_RX_IDLE;
          rx_cnt_d = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_st_q  <= uabg_pkg::UABG_RX_IDLE;
      rx_cnt_q <= 6'h00;
      rx_idx_q <= 4'h0;
      prev_q   <= 1'b1;
      start_q  <= 1'b0;
      latch_q  <= 1'b0;
      bit_q    <= 1'b1;
      end_q    <= 1'b0;
    end else begin
      rx_st_q  <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_idx_q <= rx_idx_d;
      prev_q   <= prev_d;
      start_q  <= start_d;
      latch_q  <= latch_d;
      bit_q    <= bit_d;
      end_q    <= end_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata        = rdata_q;
  assign o_base_clk_en  = base_q;
  assign o_tx_bit_tick  = tx_tick_q;
  assign o_tx_load      = tx_load_q;
  assign o_tx_data      = txd_q;
  assign o_rx_filtered  = rx_filt;
  assign o_rx_start     = start_q;
  assign o_rx_latch     = latch_q;
  assign o_rx_bit       = bit_q;
  assign o_rx_frame_end = end_q;

endmodule : uabg_baud_gen
`default_nettype wire

//--- common/uabg_pkg.sv
// package: register map, field positions, reset values and states of the baud generator / rx filter
// assumes: a single 20 MHz core clock and a plain strobe register port
package uabg_pkg;

  // ----------------------------------------------------------------
  // clock and widths
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 20_000_000;
  localparam int unsigned ADDR_W      = 2;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned K_W         = 5;
  localparam int unsigned PRE_W       = 3;
  localparam int unsigned FILT_LAG    = 2;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_DIV_CTRL  = 2'h0;
  localparam logic [1:0] OFS_MODE_CTRL = 2'h1;
  localparam logic [1:0] OFS_STATUS    = 2'h2;
  localparam logic [1:0] OFS_TX_SHIFT  = 2'h3;

  // ----------------------------------------------------------------
  // bit_rate_divider_control fields
  // ----------------------------------------------------------------
  localparam int unsigned DIV_SEL_HI = 7;
  localparam int unsigned DIV_SEL_LO = 6;
  localparam int unsigned DIV_K_MSB  = 4;
  localparam int unsigned DIV_K_LSB  = 0;
  localparam logic [7:0]  DIV_RST    = 8'h08;
  localparam logic [4:0]  K_MIN      = 5'h08;
  localparam logic [4:0]  K_MAX      = 5'h1F;

  // ----------------------------------------------------------------
  // serial_mode_control fields
  // ----------------------------------------------------------------
  localparam int unsigned MODE_POWER  = 7;
  localparam int unsigned MODE_TXE    = 6;
  localparam int unsigned MODE_RXE    = 5;
  localparam int unsigned MODE_CHAR8  = 3;
  localparam int unsigned MODE_PAR_EN = 2;
  localparam logic [7:0]  MODE_RST    = 8'h00;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int unsigned STAT_FRAME  = 7;
  localparam int unsigned STAT_CONF   = 6;
  localparam int unsigned STAT_TX_RUN = 5;
  localparam int unsigned STAT_FILT   = 4;

  // frame bits latched after the start bit: 7 data + optional 8th + optional parity + one stop
  localparam logic [3:0] RX_BITS_BASE = 4'h8;

  typedef enum logic [1:0] {
    UABG_RX_IDLE,
    UABG_RX_CONFIRM,
    UABG_RX_FRAME
  } uabg_rx_state_t;

endpackage : uabg_pkg

//--- common/uabg_filt_if.sv
// interface: carries base-clock sample enable, raw line and filtered line to the noise filter
// assumes: both ends on i_core_clk
`timescale 1ns/1ps
`default_nettype none
interface uabg_filt_if;
  logic sample_en;
  logic raw_line;
  logic filt_line;
  modport owner (output sample_en, output raw_line, input  filt_line);
  modport filt  (input  sample_en, input  raw_line, output filt_line);
endinterface : uabg_filt_if
`default_nettype wire

//--- design/uabg_rx_filter.sv
// module: two-sample match filter on the receive line
// assumes: sample_en is one core-clock pulse per base clock, held off while the unit is powered down
`timescale 1ns/1ps
`default_nettype none
module uabg_rx_filter (
  input  wire logic  i_core_clk,
  input  wire logic  i_reset_n,
  uabg_filt_if.filt  f
);

  logic samp_q;
  logic samp_d;
  logic filt_q;
  logic filt_d;

  // ----------------------------------------------------------------
  // match detector
  // ----------------------------------------------------------------
  always_comb begin
    samp_d = samp_q;
    filt_d = filt_q;
    if (f.sample_en) begin
      samp_d = f.raw_line;                                // [RL1]
      if (f.raw_line == samp_q) begin
        filt_d = f.raw_line;                              // [RL1] [RL2]
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      samp_q <= 1'b1;
      filt_q <= 1'b1;
    end else begin
      samp_q <= samp_d;
      filt_q <= filt_d;
    end
  end

  assign f.filt_line = filt_q;

endmodule : uabg_rx_filter
`default_nettype wire

//--- testbench/uabg_baud_gen_chk.sv
// checker: concurrent properties on the baud generator top ports
// assumes: bound onto uabg_baud_gen, single core clock domain
`timescale 1ns/1ps
`default_nettype none
module uabg_baud_gen_chk (
  input wire logic       i_core_clk,
  input wire logic       i_reset_n,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_serial_rx_line,
  input wire logic       o_base_clk_en,
  input wire logic       o_tx_bit_tick,
  input wire logic       o_tx_load,
  input wire logic [7:0] o_tx_data,
  input wire logic       o_rx_filtered,
  input wire logic       o_rx_start,
  input wire logic       o_rx_latch,
  input wire logic       o_rx_bit,
  input wire logic       o_rx_frame_end
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // ----------------------------------------------------------------
  // shadow registers and gap counters
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic [7:0] mode_q;
  logic [5:0] rc_q;
  logic [5:0] tc_q;
  logic [5:0] two_k;
  logic [3:0] nl_q;
  logic       ts_q;
  // k below the legal floor runs as 8
  assign two_k = (div_q[4:0] < 5'h08) ? 6'h10 : {div_q[4:0], 1'h0};
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_q  <= 8'h08;
      mode_q <= 8'h00;
      rc_q   <= 6'h00;
      tc_q   <= 6'h00;
      nl_q   <= 4'h0;
      ts_q   <= 1'h0;
    end else begin
      if (i_wr && i_addr == 2'h0) div_q <= i_wdata;
      if (i_wr && i_addr == 2'h1) mode_q <= i_wdata;
      rc_q <= (o_rx_start || o_rx_latch) ? 6'h00 : rc_q + 6'h01;
      tc_q <= (o_tx_bit_tick || o_tx_load) ? 6'h00 : tc_q + 6'h01;
      nl_q <= o_rx_start ? 4'h0 : nl_q + {3'h0, o_rx_latch};
      // a config write or a load restarts the spacing, so the next gap is not judged
      ts_q <= (o_tx_bit_tick || ts_q) && !o_tx_load && !(i_wr && !i_addr[1]);
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_base_gated: assert property ((!mode_q[7])[*3] |-> !o_base_clk_en)
    else $error("base clock while powered down");
  chk_tx_held: assert property ((!(mode_q[7] && mode_q[6]))[*3] |-> !o_tx_bit_tick)
    else $error("tx tick while disabled");
  chk_rx_held: assert property ((!(mode_q[7] && mode_q[5]))[*3] |-> !(o_rx_start || o_rx_latch))
    else $error("rx activity while disabled");
  chk_tx_load: assert property (i_wr && i_addr == 2'h3 |=> o_tx_load && o_tx_data == $past(i_wdata))
    else $error("tx load missing or wrong");
  chk_div_read: assert property (i_rd && i_addr == 2'h0 |=> o_rdata == div_q)
    else $error("divider readback wrong");
  chk_filt_base: assert property ($changed(o_rx_filtered) |-> $past(o_base_clk_en) || $past(o_base_clk_en, 2))
    else $error("filter moved without base sample");
  chk_start_low: assert property (o_rx_start |-> !o_rx_filtered)
    else $error("start accepted on high line");
  chk_frame_len: assert property (o_rx_frame_end |-> o_rx_latch && nl_q == 4'h7 + mode_q[3] + mode_q[2])
    else $error("frame latch count wrong");
  chk_rx_gap: assert property (o_rx_latch && div_q[7:6] == 2'h0 |-> rc_q == two_k - 6'h01)
    else $error("rx latch spacing wrong");
  chk_tx_gap: assert property (o_tx_bit_tick && ts_q && div_q[7:6] == 2'h0 |-> tc_q == two_k - 6'h01)
    else $error("tx tick spacing wrong");
endmodule : uabg_baud_gen_chk

bind uabg_baud_gen uabg_baud_gen_chk uabg_baud_gen_chk_inst (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_serial_rx_line(i_serial_rx_line), .o_base_clk_en(o_base_clk_en),
  .o_tx_bit_tick(o_tx_bit_tick), .o_tx_load(o_tx_load), .o_tx_data(o_tx_data), .o_rx_filtered(o_rx_filtered),
  .o_rx_start(o_rx_start), .o_rx_latch(o_rx_latch), .o_rx_bit(o_rx_bit), .o_rx_frame_end(o_rx_frame_end));
`default_nettype wire

//--- testbench/uabg_remote_tx.sv
// model: remote asynchronous transmitter driving the receive line
// assumes: bench gives frame bits and bit period in core cycles; line idles high
`timescale 1ns/1ps
`default_nettype none
module uabg_remote_tx (
  input  wire logic        i_core_clk,
  input  wire logic        i_go,
  input  wire logic [10:0] i_bits,
  input  wire logic [3:0]  i_nbits,
  input  wire logic [7:0]  i_period,
  output var  logic        o_line,
  output var  logic        o_busy
);
  logic [10:0] sh_q;
  logic [3:0]  n_q;
  logic [7:0]  c_q;
  initial begin
    o_line = 1'h1;
    o_busy = 1'h0;
  end
  // period set by the bench, kept within the receiver tolerance for slow and fast peers
  always @(posedge i_core_clk) begin
    if (i_go && !o_busy) begin
      sh_q   <= i_bits;
      n_q    <= i_nbits;
      c_q    <= i_period - 8'h01;
      o_line <= 1'h0; // start bit
      o_busy <= 1'h1;
    end else if (o_busy) begin
      if (c_q != 8'h00) begin
        c_q <= c_q - 8'h01;
      end else if (n_q == 4'h0) begin
        o_line <= 1'h1;
        o_busy <= 1'h0;
      end else begin
        o_line <= sh_q[0]; // lsb first, parity and stops ride above the data
        sh_q   <= sh_q >> 1;
        n_q    <= n_q - 4'h1;
        c_q    <= i_period - 8'h01;
      end
    end
  end
endmodule : uabg_remote_tx
`default_nettype wire

//--- testbench/test_uart_baud_generator_rx_filter.sv
// testbench: register tasks, remote transmitter and scenario sequence for the baud generator
// assumes: design, checker and transmitter model compiled before, 20 MHz core clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module test_uart_baud_generator_rx_filter;
  logic        clk, rst_n, wr, rd, go, busy, ptx, gl_n, rx_line;
  logic        base, tick, load, filt, start, latch, rbit, fend;
  logic [1:0]  addr;
  logic [7:0]  wdata, rdata, tx_data, per;
  logic [10:0] bits;
  logic [3:0]  nb;
  int          err_total, n_tests, starts, w;
  logic        lat_q[$];

  assign rx_line = ptx & gl_n;
  uabg_baud_gen uabg_baud_gen_inst (.i_core_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_serial_rx_line(rx_line), .o_base_clk_en(base),
    .o_tx_bit_tick(tick), .o_tx_load(load), .o_tx_data(tx_data), .o_rx_filtered(filt), .o_rx_start(start),
    .o_rx_latch(latch), .o_rx_bit(rbit), .o_rx_frame_end(fend));
  uabg_remote_tx uabg_remote_tx_inst (.i_core_clk(clk), .i_go(go), .i_bits(bits), .i_nbits(nb),
    .i_period(per), .o_line(ptx), .o_busy(busy));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (latch === 1'h1) lat_q.push_back(rbit);
    if (start === 1'h1) starts++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 `CHK("rdata", e, rdata)
  endtask : rd_chk
  task automatic cnt(input int sel, input int len, output int n);
    n = 0;
    repeat (len) begin
      @(posedge clk);
      #1 n += (sel == 0) ? (base === 1'h1) : (tick === 1'h1);
    end
  endtask : cnt
  task automatic wait_tick;
    w = 0;
    do begin @(posedge clk); #1 w++; end while (tick !== 1'h1 && w < 100);
  endtask : wait_tick
  // latched bits must match what was sent after the start bit, first stop bit included
  task automatic rx_frame(input logic [10:0] b, input logic [3:0] ns, input int nl, input logic [7:0] p, input int ok);
    int i;
    lat_q.delete();
    starts = 0;
    @(posedge clk);
    go <= 1'h1;
    bits <= b;
    nb <= ns;
    per <= p;
    @(posedge clk);
    go <= 1'h0;
    w = 0;
    do begin @(posedge clk); #1 w++; end while (busy === 1'h1 && w < 9000);
    repeat (8) @(posedge clk);
    `CHK("starts", ok, starts)
    `CHK("latches", nl, lat_q.size())
    for (i = 0; i < lat_q.size(); i++) `CHK("rx_bit", b[i], lat_q[i])
  endtask : rx_frame
  task automatic glitch(input int len, output int lag);
    int i;
    lag = 0;
    @(posedge clk);
    gl_n <= 1'h0;
    for (i = 1; i <= 20; i++) begin
      @(posedge clk);
      if (i == len) gl_n <= 1'h1;
      #1 if (lag == 0 && filt === 1'h0) lag = i;
    end
  endtask : glitch

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int n, s;
    rst_n = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    addr = 2'h0;
    wdata = 8'h00;
    go = 1'h0;
    bits = 11'h7FF;
    nb = 4'h0;
    per = 8'h10;
    gl_n = 1'h1;
    err_total = 0;
    n_tests = 0;
    starts = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    rd_chk(2'h0, 8'h08);
    rd_chk(2'h1, 8'h00);
    wr_reg(2'h2, 8'hFF);
    rd_chk(2'h2, 8'h10);
    rd_chk(2'h3, 8'h00);
    cnt(0, 32, n);
    `CHK("base_off", 0, n)
    wr_reg(2'h1, 8'h80);
    for (s = 0; s < 4; s++) begin
      wr_reg(2'h0, {s[1:0], 6'h08});
      repeat (8) @(posedge clk);
      cnt(0, 64, n);
      `CHK("base_rate", 64 >> s, n)
    end
    // transmit counter, k = 16 on the undivided core clock
    wr_reg(2'h0, 8'h10);
    wr_reg(2'h1, 8'hC0);
    repeat (40) @(posedge clk);
    cnt(1, 320, n);
    `CHK("tick_rate", 10, n)
    // load just before a tick is due: without the clear it would come at once
    wait_tick();
    repeat (28) @(posedge clk);
    wr_reg(2'h3, 8'h5A);
    #1 `CHK("tx_load", 1'h1, load)
    `CHK("tx_data", 8'h5A, tx_data)
    wait_tick();
    `CHK("tx_clear", 1'h1, w >= 30)
    wr_reg(2'h1, 8'h80);
    cnt(1, 100, n);
    `CHK("tick_off", 0, n)
    // receive: 8 bits no parity at k = 8, then 7 bits with parity and two stops at k = 31
    wr_reg(2'h0, 8'h08);
    wr_reg(2'h1, 8'hA8);
    repeat (8) @(posedge clk);
    rx_frame({2'h3, 9'h1A5}, 4'h9, 9, 8'h10, 1);
    wr_reg(2'h0, 8'h1F);
    wr_reg(2'h1, 8'hA4);
    repeat (8) @(posedge clk);
    rx_frame({1'h1, 10'h3B6}, 4'hA, 9, 8'h40, 1);
    rx_frame({1'h1, 10'h349}, 4'hA, 9, 8'h3C, 1);
    // noise filter, false start, then a frame with the receiver disabled
    wr_reg(2'h0, 8'h08);
    wr_reg(2'h1, 8'hA8);
    repeat (8) @(posedge clk);
    starts = 0;
    glitch(1, n);
    `CHK("glitch_pass", 0, n)
    glitch(4, n);
    `CHK("filt_lag", 2, n)
    repeat (40) @(posedge clk);
    `CHK("false_start", 0, starts)
    wr_reg(2'h1, 8'h88);
    repeat (4) @(posedge clk);
    rx_frame({2'h3, 9'h1A5}, 4'h9, 0, 8'h10, 0);
    complete_run();
  end

  // the sequence needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule : test_uart_baud_generator_rx_filter
`default_nettype wire
